//--- qcz_top.sv
// qcz_top.sv: quadrature counter with zeroing control, scaling profiles and APB registers
`timescale 1ns/10ps
`default_nettype none
`include "qcz_cfg.svh"
module qcz_top
  import qcz_pkg::*;
#(
  parameter int FILT_CYCLES = `QCZ_ZERO_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic [1:0] prog_in,
  input wire logic relay_one_switching,
  output logic count_dir_rev
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] ctrl;
    logic [31:0] thr1;
    logic [31:0] thr2;
    logic [3:0][20:0] mul;
    logic [3:0][19:0] div;
    logic [3:0][20:0] off;
    logic [3:0][2:0] point;
    logic [31:0] main_acc;
    logic [31:0] cyc;
    logic [31:0] tot;
    logic [19:0] resid;
    logic [2:0] key_pend;
    qcz_key_t key_st;
    logic relay_prev;
    logic dir;
  } qcz_top_st_t;
  qcz_top_st_t q, d;

  logic [1:0] in_lvl;
  logic [1:0] in_rise;
  logic step_up;
  logic step_dn;
  logic [1:0] prof;
  logic signed [31:0] cur_mul;
  logic signed [31:0] cur_off;
  logic [19:0] cur_div;
  logic marker;
  logic az_en;
  qcz_zsrc_t zsrc [3];
  qcz_func_t func [2];
  logic [2:0] allow_key;
  logic [2:0] allow_ext;
  logic [2:0] allow_rem;
  logic [2:0] ext_zero;
  logic dir_d;
  logic setup;
  logic access;
  logic signed [31:0] wsig;
  logic w_in_rng;

  // ****************************************************************
  // input conditioning and decoding
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      qcz_in_filter #(.FILT_CYCLES(FILT_CYCLES)) u_flt (
        .pclk(pclk),
        .presetn(presetn),
        .raw(prog_in[gi]),
        .level(in_lvl[gi]),
        .rise(in_rise[gi])
      );
      assign func[gi] = qcz_func_t'(q.ctrl[(gi ? 17 : 13) -: 4]);
    end
    for (gi = 0; gi < 3; gi++) begin : g_zs
      assign zsrc[gi] = qcz_zsrc_t'(q.ctrl[4 + 2 * gi +: 2]);
      // key and external paths honour each counter's own choice
      assign allow_key[gi] = (zsrc[gi] == QCZ_Z_FRONT_KEY_ONLY) || (zsrc[gi] == QCZ_Z_BOTH);
      assign allow_ext[gi] = (zsrc[gi] == QCZ_Z_EXTERNAL_SIGNAL_ONLY) || (zsrc[gi] == QCZ_Z_BOTH);
      assign allow_rem[gi] = zsrc[gi] != QCZ_Z_NONE;
    end
  endgenerate

  qcz_quad_dec u_dec (
    .pclk(pclk),
    .presetn(presetn),
    .phase_a(phase_a),
    .phase_b(phase_b),
    .dir_rev(q.dir),
    .step_up(step_up),
    .step_dn(step_dn)
  );

  // only inputs set to direction toggle take part in the xor
  assign dir_d = q.ctrl[`QCZ_C_REV] ^ (func[0] == QCZ_F_DIR_TOGGLE && in_lvl[0])
    ^ (func[1] == QCZ_F_DIR_TOGGLE && in_lvl[1]);

  // codes 1..7 form a {tot,cyc,main} mask; gated per counter by its source choice
  assign ext_zero = allow_ext & (((func[0] <= QCZ_F_ZERO_ALL && in_rise[0]) ? q.ctrl[12:10] : 3'h0)
    | ((func[1] <= QCZ_F_ZERO_ALL && in_rise[1]) ? q.ctrl[16:14] : 3'h0));

  // ****************************************************************
  // current profile
  // ****************************************************************
  assign prof = q.ctrl[`QCZ_C_PROF];
  assign marker = q.ctrl[`QCZ_C_MARKER];
  assign az_en = q.ctrl[`QCZ_C_AZ];
  assign cur_mul = {{11{q.mul[prof][20]}}, q.mul[prof]};
  assign cur_off = {{11{q.off[prof][20]}}, q.off[prof]};
  assign cur_div = q.div[prof];
  assign setup = psel && !penable;
  assign access = psel && penable && q.pready;
  assign wsig = $signed(pwdata);
  assign w_in_rng = (wsig >= `QCZ_VAL_MIN) && (wsig <= `QCZ_VAL_MAX);

  // ****************************************************************
  // next state
  // ****************************************************************
  logic scl_up;
  logic scl_dn;
  logic signed [31:0] delta;
  logic signed [31:0] main_new;
  logic signed [31:0] cyc_new;
  logic az_main;
  logic az_cyc;
  logic relay_rise;
  logic [2:0] clr;
  logic bad_wr;
  logic unmapped;

  always_comb begin
    d = q;
    d.dir = dir_d;
    // divisor as modulo counter: one scaled step per div raw pulses, rounding down
    scl_up = 1'b0;
    scl_dn = 1'b0;
    if (step_up) begin
      if (q.resid >= cur_div - 20'h0_0001) begin
        d.resid = 20'h0_0000;
        scl_up = 1'b1;
      end else begin
        d.resid = q.resid + 20'h0_0001;
      end
    end else if (step_dn) begin
      if (q.resid == 20'h0_0000) begin
        d.resid = cur_div - 20'h0_0001;
        scl_dn = 1'b1;
      end else begin
        d.resid = q.resid - 20'h0_0001;
      end
    end
    delta = scl_up ? cur_mul : (scl_dn ? -cur_mul : 32'sh0);
    main_new = $signed(q.main_acc) + delta;
    cyc_new = $signed(q.cyc) + delta;
    // threshold is reached when the shown value crosses it upward
    az_main = (marker || az_en) && scl_up && ($signed(q.main_acc) + cur_off < $signed(q.thr1))
      && (main_new + cur_off >= $signed(q.thr1));
    az_cyc = marker && az_en && scl_up && ($signed(q.cyc) < $signed(q.thr2))
      && (cyc_new >= $signed(q.thr2));
    relay_rise = relay_one_switching && !q.relay_prev;
    d.relay_prev = relay_one_switching;
    d.main_acc = az_main ? 32'h0 : main_new;
    d.tot = $signed(q.tot) + delta;
    if (marker) begin
      d.cyc = az_cyc ? 32'h0 : cyc_new;
    end else if (q.ctrl[`QCZ_C_CYCAZ]) begin
      d.cyc = q.cyc + {31'h0, az_main};
    end else begin
      d.cyc = q.cyc + {31'h0, relay_rise};
    end
    clr = ext_zero;
    // apb slave: answer one cycle after setup, data and error prepared in setup
    unmapped = (paddr[1:0] != 2'h0) || (paddr > `QCZ_A_KEY);
    bad_wr = 1'b0;
    if (pwrite) begin
      case (paddr)
        `QCZ_A_MUL, `QCZ_A_OFF, `QCZ_A_THR1, `QCZ_A_THR2: bad_wr = !w_in_rng;
        `QCZ_A_DIV: bad_wr = (pwdata == 32'h0) || (pwdata > `QCZ_VAL_MAX);
        `QCZ_A_POINT: bad_wr = pwdata > `QCZ_POINT_MAX;
        `QCZ_A_MAIN, `QCZ_A_CYC, `QCZ_A_TOT: bad_wr = pwdata != 32'h0;
        default: bad_wr = 1'b0;
      endcase
    end
    d.pready = setup;
    d.pslverr = setup && (unmapped || bad_wr);
    d.prdata = 32'h0;
    if (setup && !pwrite) begin
      case (paddr)
        `QCZ_A_CTRL: d.prdata = q.ctrl;
        `QCZ_A_THR1: d.prdata = q.thr1;
        `QCZ_A_THR2: d.prdata = q.thr2;
        `QCZ_A_MUL: d.prdata = cur_mul;
        `QCZ_A_DIV: d.prdata = {12'h000, cur_div};
        `QCZ_A_OFF: d.prdata = cur_off;
        `QCZ_A_POINT: d.prdata = {29'h0, q.point[prof]};
        `QCZ_A_MAIN: d.prdata = q.main_acc + cur_off;
        `QCZ_A_CYC: d.prdata = q.cyc;
        `QCZ_A_TOT: d.prdata = q.tot;
        `QCZ_A_KEY: d.prdata = {25'h0, q.dir, in_lvl, q.key_st, q.key_pend};
        default: d.prdata = 32'h0;
      endcase
    end
    if (access && pwrite && !q.pslverr) begin
      case (paddr)
        `QCZ_A_CTRL: d.ctrl = {12'h000, pwdata[`QCZ_C_USED-1:0]};
        `QCZ_A_THR1: d.thr1 = pwdata;
        `QCZ_A_THR2: d.thr2 = pwdata;
        `QCZ_A_MUL: d.mul[prof] = pwdata[20:0];
        `QCZ_A_DIV: d.div[prof] = pwdata[19:0];
        `QCZ_A_OFF: d.off[prof] = pwdata[20:0];
        `QCZ_A_POINT: d.point[prof] = pwdata[2:0];
        `QCZ_A_MAIN: clr[0] = clr[0] | allow_rem[0];
        `QCZ_A_CYC: clr[1] = clr[1] | allow_rem[1];
        `QCZ_A_TOT: clr[2] = clr[2] | allow_rem[2];
        `QCZ_A_KEY: begin
          // front key: request first, enter confirms, escape drops it
          if (pwdata[`QCZ_K_ESC]) begin
            d.key_st = QCZ_KEY_IDLE;
            d.key_pend = 3'h0;
          end else if (pwdata[`QCZ_K_ENTER] && q.key_st == QCZ_KEY_WAIT_ENTER) begin
            clr = clr | (q.key_pend & allow_key);
            d.key_st = QCZ_KEY_IDLE;
            d.key_pend = 3'h0;
          end else if ((pwdata[2:0] & allow_key) != 3'h0) begin
            d.key_pend = pwdata[2:0] & allow_key;
            d.key_st = QCZ_KEY_WAIT_ENTER;
          end
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    // zeroing wins over counting in the same cycle
    if (clr[0]) begin
      d.main_acc = 32'h0;
      d.resid = 20'h0_0000;
    end
    if (clr[1]) begin
      d.cyc = 32'h0;
    end
    if (clr[2]) begin
      d.tot = 32'h0;
    end
  end

  // profiles reset to unity scale so counting works before any setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= `QCZ_CTRL_RST;
      q.mul <= {4{`QCZ_MUL_RST}};
      q.div <= {4{`QCZ_DIV_RST}};
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign count_dir_rev = q.dir;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_ready_next: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer not exactly one cycle after setup");
  a_div_never_zero: assert property (cur_div != 20'h0_0000)
    else $error("current divisor is zero");
  a_div_zero_reject: assert property (setup && pwrite && paddr == `QCZ_A_DIV && pwdata == 32'h0
    |=> pslverr)
    else $error("zero divisor write not refused");
  a_std_auto_zero: assert property (!marker && !az_en && !clr[0] |=> q.main_acc != 32'h0
    || $past(main_new) == 32'sh0)
    else $error("main cleared with auto-zero off in standard mode");
  a_marker_main_zero: assert property (marker && az_main |=> q.main_acc == 32'h0)
    else $error("marker mode main counter not auto-zeroed");
  a_cyc_thr_zero: assert property (az_cyc |=> q.cyc == 32'h0)
    else $error("cycles counter not cleared at threshold two");
  a_cyc_no_az_inc: assert property (!marker && q.ctrl[`QCZ_C_CYCAZ] && !az_en
    |=> q.cyc == $past(q.cyc) || q.cyc == 32'h0)
    else $error("cycles counter moved with auto-zero disabled");
  a_relay_one_count: assert property (!marker && !q.ctrl[`QCZ_C_CYCAZ] && relay_rise && !clr[1]
    |=> q.cyc == $past(q.cyc) + 32'h1)
    else $error("relay one switching not counted");
  a_key_ext_only: assert property (zsrc[0] == QCZ_Z_EXTERNAL_SIGNAL_ONLY && !ext_zero[0]
    && !(access && pwrite && paddr == `QCZ_A_MAIN) |=> q.main_acc != 32'h0
    || $past(main_new) == 32'sh0 || $past(az_main))
    else $error("main counter zeroed by key in external-only mode");
  a_dir_xor_follow: assert property (##1 count_dir_rev == $past(dir_d))
    else $error("count direction does not follow the xor");
  a_rem_zero_main: assert property (access && pwrite && paddr == `QCZ_A_MAIN
    && !pslverr && zsrc[0] != QCZ_Z_NONE |=> q.main_acc == 32'h0)
    else $error("remote zero of main counter not applied");
  a_key_escape: assert property (access && pwrite && paddr == `QCZ_A_KEY
    && pwdata[`QCZ_K_ESC] |=> q.key_st == QCZ_KEY_IDLE && q.key_pend == 3'h0)
    else $error("escape did not drop the pending key request");
  c_marker_wrap: cover property (marker && az_main);
  c_dir_toggle: cover property ($rose(count_dir_rev));
  c_ext_zero: cover property (ext_zero != 3'h0);
  c_key_confirm: cover property (q.key_st == QCZ_KEY_WAIT_ENTER ##[1:20] q.key_st == QCZ_KEY_IDLE);
endmodule : qcz_top
`default_nettype wire

//--- qcz_cfg.svh
// qcz_cfg.svh: offsets, field positions, reset values and timing counts of the counter block
`ifndef QCZ_CFG_SVH
`define QCZ_CFG_SVH
// register byte offsets
`define QCZ_A_CTRL 8'h00
`define QCZ_A_THR1 8'h04
`define QCZ_A_THR2 8'h08
`define QCZ_A_MUL 8'h0c
`define QCZ_A_DIV 8'h10
`define QCZ_A_OFF 8'h14
`define QCZ_A_POINT 8'h18
`define QCZ_A_MAIN 8'h1c
`define QCZ_A_CYC 8'h20
`define QCZ_A_TOT 8'h24
`define QCZ_A_KEY 8'h28
// control register fields
`define QCZ_C_MARKER 0
`define QCZ_C_AZ 1
`define QCZ_C_CYCAZ 2
`define QCZ_C_REV 3
`define QCZ_C_ZM 5:4
`define QCZ_C_ZC 7:6
`define QCZ_C_ZT 9:8
`define QCZ_C_IN1 13:10
`define QCZ_C_IN2 17:14
`define QCZ_C_PROF 19:18
`define QCZ_C_USED 20
// key register write bits: 2:0 request mask, 3 enter, 4 escape
`define QCZ_K_ENTER 3
`define QCZ_K_ESC 4
// reset values and limits
`define QCZ_CTRL_RST 32'h0000_0000
`define QCZ_MUL_RST 21'h00_0001
`define QCZ_DIV_RST 20'h0_0001
`define QCZ_VAL_MIN (-99999)
`define QCZ_VAL_MAX 999999
`define QCZ_POINT_MAX 5
// timing: least active time of an external zeroing pulse
`define QCZ_ZERO_TIME_NS 1000000
`define QCZ_CLK_NS 8
`define QCZ_ZERO_CYCLES ((`QCZ_ZERO_TIME_NS + `QCZ_CLK_NS - 1) / `QCZ_CLK_NS)
`endif

//--- qcz_pkg.sv
// qcz_pkg.sv: types shared by the quadrature counter block
`include "qcz_cfg.svh"
package qcz_pkg;
  // zeroing source choice per counter
  typedef enum logic [1:0] {
    QCZ_Z_FRONT_KEY_ONLY = 2'h0,
    QCZ_Z_EXTERNAL_SIGNAL_ONLY = 2'h1,
    QCZ_Z_BOTH = 2'h2,
    QCZ_Z_NONE = 2'h3
  } qcz_zsrc_t;
  // programmable input function; codes 1..7 are a {tot,cyc,main} mask
  typedef enum logic [3:0] {
    QCZ_F_INPUT_OFF = 4'h0,
    QCZ_F_ZERO_ALL = 4'h7,
    QCZ_F_DIR_TOGGLE = 4'h8
  } qcz_func_t;
  // front key confirmation states
  typedef enum logic [0:0] {
    QCZ_KEY_IDLE = 1'h0,
    QCZ_KEY_WAIT_ENTER = 1'h1
  } qcz_key_t;
endpackage : qcz_pkg

//--- qcz_in_filter.sv
// qcz_in_filter.sv: synchroniser and minimum-width filter for one programmable input
`timescale 1ns/10ps
`default_nettype none
`include "qcz_cfg.svh"
module qcz_in_filter
  import qcz_pkg::*;
#(
  parameter int FILT_CYCLES = `QCZ_ZERO_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw,
  output logic level,
  output logic rise
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [16:0] cnt;
    logic lvl;
    logic rise;
  } qcz_flt_st_t;
  qcz_flt_st_t q, d;

  // level only rises after the input stayed active beyond the filter time
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.rise = 1'b0;
    if (!q.s2) begin
      d.cnt = 17'h0_0000;
      d.lvl = 1'b0;
    end else if (q.cnt == 17'(FILT_CYCLES)) begin
      d.rise = !q.lvl;
      d.lvl = 1'b1;
    end else begin
      d.cnt = q.cnt + 17'h0_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
  assign rise = q.rise;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_filter_min_width: assert property (q.rise
    |-> $past(q.s2) && $past(q.cnt) == 17'(FILT_CYCLES))
    else $error("filtered input rose before the minimum width");
  a_filter_drop: assert property (!q.s2 |=> !q.lvl)
    else $error("filtered level kept after input went inactive");
endmodule : qcz_in_filter
`default_nettype wire

//--- qcz_quad_dec.sv
// qcz_quad_dec.sv: quadrature decoder giving one up or down step per edge
`timescale 1ns/10ps
`default_nettype none
module qcz_quad_dec
  import qcz_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic phase_a,
  input wire logic phase_b,
  input wire logic dir_rev,
  output logic step_up,
  output logic step_dn
);
  typedef struct packed {
    logic [1:0] ab;
    logic up;
    logic dn;
  } qcz_dec_st_t;
  qcz_dec_st_t q, d;
  logic fwd;
  logic bwd;

  // forward sequence 00-01-11-10; an illegal double jump counts nothing
  always_comb begin
    fwd = 1'b0;
    bwd = 1'b0;
    case ({q.ab, phase_a, phase_b})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: fwd = 1'b1;
      4'b0100, 4'b1101, 4'b1011, 4'b0010: bwd = 1'b1;
      default: begin
        fwd = 1'b0;
        bwd = 1'b0;
      end
    endcase
    d.ab = {phase_a, phase_b};
    d.up = dir_rev ? bwd : fwd;
    d.dn = dir_rev ? fwd : bwd;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign step_up = q.up;
  assign step_dn = q.dn;
endmodule : qcz_quad_dec
`default_nettype wire

//--- qcz_enc_model.sv
// qcz_enc_model.sv: quadrature sensor and external input model for the counter bench
`timescale 1ns/10ps
`default_nettype none
module qcz_enc_model (
  input wire logic pclk,
  output logic phase_a,
  output logic phase_b,
  output logic [1:0] prog_in,
  output logic relay_one_switching
);
  // ******************************
  // sensor state
  // ******************************
  logic [1:0] pos_q;

  // all lines idle low from time zero
  initial begin
    pos_q = 2'h0;
    phase_a = 1'b0;
    phase_b = 1'b0;
    prog_in = 2'h0;
    relay_one_switching = 1'b0;
  end

  // one gray edge per step; phase b leads a when moving up, as the decoder expects
  task automatic step(input int n, input logic up);
    logic [1:0] nx;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      nx = up ? pos_q + 2'h1 : pos_q - 2'h1;
      pos_q <= nx;
      phase_a <= nx[1];
      phase_b <= nx[1] ^ nx[0];
      repeat (6) @(posedge pclk); // spacing keeps every edge apart
    end
  endtask : step

  // ******************************
  // external inputs
  // ******************************
  // level change on one programmable input
  task automatic set_in(input int idx, input logic val);
    @(posedge pclk);
    prog_in[idx] <= val;
  endtask : set_in

  // active pulse; a zeroing pulse must outlast the filter time
  task automatic hold(input int idx, input int cycles);
    set_in(idx, 1'b1);
    repeat (cycles) @(posedge pclk);
    prog_in[idx] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : hold

  // one switching of relay one
  task automatic relay_pulse();
    @(posedge pclk);
    relay_one_switching <= 1'b1;
    repeat (4) @(posedge pclk);
    relay_one_switching <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : relay_pulse
endmodule : qcz_enc_model
`default_nettype wire

//--- test_quadrature_counter_reset_scaling.sv
// test_quadrature_counter_reset_scaling.sv: self-checking bench of the quadrature counter block
`timescale 1ns/10ps
`default_nettype none
`include "qcz_cfg.svh"
module test_quadrature_counter_reset_scaling
  import qcz_pkg::*;
;
  // short filter keeps the run brief; every zeroing pulse length derives from it
  localparam int FILT = 8;
  localparam int LIMIT = 40000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic count_dir_rev;
  logic phase_a;
  logic phase_b;
  logic relay;
  logic [1:0] prog_in;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  // ******************************
  // clock, design and sensor
  // ******************************
  always #4 pclk = ~pclk;

  qcz_top #(.FILT_CYCLES(FILT)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .phase_a(phase_a), .phase_b(phase_b),
    .prog_in(prog_in), .relay_one_switching(relay), .count_dir_rev(count_dir_rev));

  qcz_enc_model i_enc (.pclk(pclk), .phase_a(phase_a), .phase_b(phase_b),
    .prog_in(prog_in), .relay_one_switching(relay));

  // ******************************
  // helpers
  // ******************************
  task automatic end_sim();
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // a hang anywhere counts as a mismatch
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic wre(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask : wre

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd

  // control word: marker, auto zero, cycles source, reverse, sources, functions, profile
  function automatic logic [31:0] ctl(input logic mk, input logic az, input logic caz,
      input logic rev, input logic [1:0] zm, input logic [1:0] zc, input logic [1:0] zt,
      input logic [3:0] f1, input logic [3:0] f2, input logic [1:0] pr);
    return {12'h000, pr, f2, f1, zt, zc, zm, rev, caz, az, mk};
  endfunction : ctl

  // remote zero of all three counters, effective while sources are not none
  task automatic zero_all();
    wr(`QCZ_A_MAIN, 32'h0);
    wr(`QCZ_A_CYC, 32'h0);
    wr(`QCZ_A_TOT, 32'h0);
  endtask : zero_all

  // direction case: settle the filtered levels, then look at the output
  task automatic dir_case(input logic [3:0] f2, input logic rev, input logic [1:0] lv,
                          input logic expd);
    wr(`QCZ_A_CTRL, ctl(0, 0, 0, rev, 0, 0, 0, QCZ_F_DIR_TOGGLE, f2, 0));
    i_enc.set_in(0, lv[0]);
    i_enc.set_in(1, lv[1]);
    repeat (FILT + 8) @(posedge pclk);
    chk({31'h0, count_dir_rev}, {31'h0, expd});
  endtask : dir_case

  // ******************************
  // test sequence
  // ******************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`QCZ_A_CTRL, 32'h0);
    rd(`QCZ_A_MUL, 32'h1);
    rd(`QCZ_A_DIV, 32'h1);
    wre(8'h2c, 32'h0, 1'b1);
    // limits of the scaling factors
    wre(`QCZ_A_DIV, 32'h0, 1'b1);
    rd(`QCZ_A_DIV, 32'h1);
    wre(`QCZ_A_DIV, 32'h000f_4240, 1'b1);
    wre(`QCZ_A_DIV, 32'h000f_423f, 1'b0);
    wre(`QCZ_A_MUL, 32'h000f_4240, 1'b1);
    wre(`QCZ_A_MUL, 32'hfffe_7960, 1'b1);
    wre(`QCZ_A_MUL, 32'hfffe_7961, 1'b0);
    wre(`QCZ_A_OFF, 32'hfffe_7960, 1'b1);
    wre(`QCZ_A_OFF, 32'h000f_423f, 1'b0);
    // scaling: five pulses over divisor two give two steps of three
    wr(`QCZ_A_DIV, 32'h2);
    wr(`QCZ_A_MUL, 32'h3);
    wr(`QCZ_A_OFF, 32'ha);
    zero_all();
    i_enc.step(5, 1'b1);
    rd(`QCZ_A_MAIN, 32'h10);
    rd(`QCZ_A_TOT, 32'h6);
    // a second profile keeps its own factors
    wr(`QCZ_A_CTRL, ctl(0, 0, 0, 0, 0, 0, 0, 0, 0, 1));
    rd(`QCZ_A_MUL, 32'h1);
    wr(`QCZ_A_MUL, 32'h7);
    wr(`QCZ_A_CTRL, 32'h0);
    rd(`QCZ_A_MUL, 32'h3);
    wr(`QCZ_A_MUL, 32'h1);
    wr(`QCZ_A_DIV, 32'h1);
    wr(`QCZ_A_OFF, 32'h0);
    // reverse setting turns up pulses into down counts
    zero_all();
    i_enc.step(3, 1'b1);
    wr(`QCZ_A_CTRL, ctl(0, 0, 0, 1, 0, 0, 0, 0, 0, 0));
    // the direction flop follows a control write one edge later
    repeat (2) @(posedge pclk);
    chk({31'h0, count_dir_rev}, 32'h1);
    i_enc.step(2, 1'b1);
    rd(`QCZ_A_MAIN, 32'h1);
    // standard mode auto zero at threshold one, counted by cycles
    zero_all();
    wr(`QCZ_A_THR1, 32'h3);
    wr(`QCZ_A_CTRL, ctl(0, 1, 1, 0, 0, 0, 0, 0, 0, 0));
    i_enc.step(3, 1'b1);
    rd(`QCZ_A_MAIN, 32'h0);
    rd(`QCZ_A_CYC, 32'h1);
    wr(`QCZ_A_CTRL, ctl(0, 0, 1, 0, 0, 0, 0, 0, 0, 0));
    i_enc.step(3, 1'b1);
    rd(`QCZ_A_MAIN, 32'h3);
    rd(`QCZ_A_CYC, 32'h1);
    wr(`QCZ_A_CTRL, 32'h0);
    i_enc.relay_pulse();
    i_enc.relay_pulse();
    rd(`QCZ_A_CYC, 32'h3);
    // marker mode: main always auto zeroes, cycles only when enabled
    zero_all();
    wr(`QCZ_A_THR1, 32'h2);
    wr(`QCZ_A_THR2, 32'h5);
    wr(`QCZ_A_CTRL, ctl(1, 0, 0, 0, 0, 0, 0, 0, 0, 0));
    i_enc.step(3, 1'b1);
    rd(`QCZ_A_MAIN, 32'h1);
    rd(`QCZ_A_CYC, 32'h3);
    wr(`QCZ_A_CTRL, ctl(1, 1, 0, 0, 0, 0, 0, 0, 0, 0));
    i_enc.step(2, 1'b1);
    rd(`QCZ_A_MAIN, 32'h1);
    rd(`QCZ_A_CYC, 32'h0);
    // front key per counter source: external, key, none
    wr(`QCZ_A_CTRL, 32'h0);
    zero_all();
    i_enc.step(2, 1'b1);
    i_enc.relay_pulse();
    wr(`QCZ_A_CTRL, ctl(0, 0, 0, 0, 1, 0, 3, 0, 0, 0));
    wr(`QCZ_A_KEY, 32'h7);
    wr(`QCZ_A_KEY, 32'h8);
    rd(`QCZ_A_MAIN, 32'h2);
    rd(`QCZ_A_CYC, 32'h0);
    rd(`QCZ_A_TOT, 32'h2);
    i_enc.relay_pulse();
    wr(`QCZ_A_KEY, 32'h2);
    wr(`QCZ_A_KEY, 32'h10);
    wr(`QCZ_A_KEY, 32'h8);
    rd(`QCZ_A_CYC, 32'h1);
    wre(`QCZ_A_TOT, 32'h0, 1'b0);
    rd(`QCZ_A_TOT, 32'h2);
    wre(`QCZ_A_MAIN, 32'h5, 1'b1);
    wr(`QCZ_A_CTRL, 32'h0);
    wr(`QCZ_A_KEY, 32'h1);
    rd(`QCZ_A_MAIN, 32'h2);
    wr(`QCZ_A_KEY, 32'h8);
    rd(`QCZ_A_MAIN, 32'h0);
    // a pulse shorter than the filter time clears nothing
    wr(`QCZ_A_CTRL, ctl(0, 0, 0, 0, 1, 1, 1, QCZ_F_ZERO_ALL, 0, 0));
    i_enc.step(1, 1'b1);
    i_enc.hold(0, FILT - 3);
    rd(`QCZ_A_MAIN, 32'h1);
    // every zeroing function of input one against its counter mask
    for (int f = 1; f <= 7; f++) begin
      wr(`QCZ_A_CTRL, ctl(0, 0, 0, 0, 1, 1, 1, f[3:0], 0, 0));
      zero_all();
      i_enc.step(1, 1'b1);
      i_enc.relay_pulse();
      i_enc.hold(0, FILT + 12);
      rd(`QCZ_A_MAIN, {31'h0, ~f[0]});
      rd(`QCZ_A_CYC, {31'h0, ~f[1]});
      rd(`QCZ_A_TOT, {31'h0, ~f[2]});
    end
    // input zeroing refused while the source is front key only; main is moved off zero first
    wr(`QCZ_A_CTRL, ctl(0, 0, 0, 0, 0, 1, 1, 4'h1, 0, 0));
    i_enc.step(1, 1'b1);
    i_enc.hold(0, FILT + 12);
    rd(`QCZ_A_MAIN, 32'h1);
    // direction is the xor of the setting and toggle inputs only
    dir_case(QCZ_F_DIR_TOGGLE, 1'b0, 2'b00, 1'b0);
    dir_case(QCZ_F_DIR_TOGGLE, 1'b0, 2'b01, 1'b1);
    dir_case(QCZ_F_DIR_TOGGLE, 1'b0, 2'b11, 1'b0);
    dir_case(QCZ_F_INPUT_OFF, 1'b0, 2'b11, 1'b1);
    dir_case(QCZ_F_INPUT_OFF, 1'b1, 2'b01, 1'b0);
    end_sim();
  end
endmodule : test_quadrature_counter_reset_scaling
`default_nettype wire
